// >>> dv/irq_service_tracking_eoi_poll_tb.sv
/* Self-checking bench of isv_service_track.
   Assumes the request model and checker files are compiled first. */
`timescale 1ns/10ps
module irq_service_tracking_eoi_poll_tb
	import isv_pkg::*;
;
	// ============================================================
	// stimulus
	logic mclk = 0, sys_rst = 1, regRd = 0, regWr = 0, vectorAck = 0;
	logic nmiActive = 0, slaveMode = 0, ackValid, interruptPending, dmaSuspend;
	logic [7:0] regAddr = 0, maskBits = 0, raiseReq = 0;
	logic [7:0] requestClear, serviceActive, requestBits;
	logic [15:0] regWrData = 0, regRdData;
	logic [4:0] ackType;
	logic [2:0] timerRequest = 0;
	isv_levels_type srcLevel = {8{3'h3}};
	int mismatches = 0, compares = 0, cycles = 0;
	always #12.5 mclk = ~mclk;
	isv_req_model u_req (.mclk, .sys_rst, .raiseReq, .requestClear, .requestBits);
	isv_service_track u_dut (.mclk, .sys_rst, .regAddr, .regRd, .regWr, .regWrData,
		.regRdData, .requestBits, .maskBits, .srcLevel, .priorityMask(3'h7),
		.vectorAck, .timerRequest, .nmiActive, .slaveMode, .requestClear,
		.serviceActive, .ackType, .ackValid, .interruptPending, .dmaSuspend);
	task automatic close_out;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(negedge mclk);
		regAddr = a;
		regRd = !w;
		regWr = w;
		regWrData = d;
		@(negedge mclk);
		regRd = 1'b0;
		regWr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		acc(a, 1'b0, 16'h0000);
		chk(regRdData, exp);
	endtask
	task automatic raise(input logic [7:0] b);
		@(negedge mclk);
		raiseReq = b;
		@(negedge mclk);
		raiseReq = 8'h00;
		repeat (2) @(negedge mclk);
	endtask
	task automatic t_reset;
		rd(8'h2C, 16'h0000);
		rd(8'h24, 16'h0000);
		rd(8'h30, 16'h0000);
		rd(8'h40, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_suspend;
		maskBits = 8'h01;
		acc(8'h30, 1'b1, 16'h8000);
		rd(8'h30, 16'h8000);
		slaveMode = 1'b1;
		repeat (2) @(negedge mclk);
		chk({15'h0000, dmaSuspend}, 16'h0000);
		slaveMode = 1'b0;
		acc(8'h30, 1'b1, 16'h0000);
		nmiActive = 1'b1;
		rd(8'h30, 16'h8000);
		nmiActive = 1'b0;
		acc(8'h30, 1'b1, 16'h0000);
		rd(8'h30, 16'h0000);
		maskBits = 8'h00;
		$display("test suspend done");
	endtask
	task automatic t_poll;
		raise(8'h40);
		chk({15'h0000, interruptPending}, 16'h0001);
		rd(8'h26, 16'h800E);
		rd(8'h26, 16'h800E);
		rd(8'h24, 16'h800E);
		rd(8'h2C, 16'h0040);
		chk({8'h00, serviceActive}, 16'h0040);
		chk({15'h0000, interruptPending}, 16'h0000);
		chk({8'h00, requestBits}, 16'h0000);
		repeat (2) @(negedge mclk);
		rd(8'h26, 16'h0000);
		$display("test poll done");
	endtask
	task automatic t_nest;
		raise(8'h04);
		rd(8'h26, 16'h0000);
		srcLevel[2] = 3'h1;
		repeat (2) @(negedge mclk);
		rd(8'h26, 16'h800A);
		@(negedge mclk);
		vectorAck = 1'b1;
		@(negedge mclk);
		vectorAck = 1'b0;
		chk({ackValid, 10'h000, ackType}, 16'h800A);
		repeat (2) @(negedge mclk);
		rd(8'h2C, 16'h0044);
		acc(8'h22, 1'b1, 16'h8000);
		rd(8'h2C, 16'h0040);
		acc(8'h22, 1'b1, 16'h000E);
		rd(8'h2C, 16'h0000);
		acc(8'h22, 1'b1, 16'h000E);
		acc(8'h22, 1'b1, 16'h8000);
		rd(8'h2C, 16'h0000);
		$display("test nest done");
	endtask
	task automatic t_timer;
		@(negedge mclk);
		timerRequest = 3'h5;
		@(negedge mclk);
		timerRequest = 3'h0;
		rd(8'h30, 16'h0005);
		raise(8'h01);
		rd(8'h24, 16'h8008);
		repeat (2) @(negedge mclk);
		rd(8'h30, 16'h0004);
		rd(8'h2C, 16'h0001);
		acc(8'h22, 1'b1, 16'h0008);
		rd(8'h2C, 16'h0000);
		$display("test timer done");
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		t_reset;
		t_suspend;
		t_poll;
		t_nest;
		t_timer;
		close_out;
	end
endmodule
bind isv_service_track isv_track_asserts u_chk (.mclk, .sys_rst, .regAddr, .regRd,
	.regRdData, .vectorAck, .nmiActive, .slaveMode, .requestClear, .serviceActive,
	.ackType, .ackValid, .interruptPending, .dmaSuspend);

// >>> dv/isv_req_model.sv
/* Request latch model of the far side.
   Assumes requestClear pulses come from the block on mclk. */
`timescale 1ns/10ps
module isv_req_model (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [7:0]  raiseReq,
	input wire logic [7:0]  requestClear,
	output logic     [7:0]  requestBits
);
	// ============================================================
	// latch
	logic [7:0] req_q;
	assign requestBits = req_q;
	// a request waits until acknowledged
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			req_q <= 8'h00;
		end else begin
			req_q <= (req_q | raiseReq) & ~requestClear;
		end
	end
endmodule

// >>> dv/isv_track_asserts.sv
/* Port checker of isv_service_track.
   Assumes it is bound to that module and sees only its ports. */
`timescale 1ns/10ps
module isv_track_asserts (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [7:0]  regAddr,
	input wire logic        regRd,
	input wire logic [15:0] regRdData,
	input wire logic        vectorAck,
	input wire logic        nmiActive,
	input wire logic        slaveMode,
	input wire logic [7:0]  requestClear,
	input wire logic [7:0]  serviceActive,
	input wire logic [4:0]  ackType,
	input wire logic        ackValid,
	input wire logic        interruptPending,
	input wire logic        dmaSuspend
);
	// ============================================================
	// properties
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire pollRd = regRd && regAddr == 8'h24 && !vectorAck;
	wire viewRd = regRd && regAddr == 8'h26 && !vectorAck;

	AST_RST: assert property ($fell(sys_rst) |-> serviceActive == 8'h00 && !dmaSuspend)
		else $error("outputs not clear after reset");
	AST_ACK: assert property (vectorAck && interruptPending |=> ackValid && requestClear != 8'h00)
		else $error("vectoring acknowledge lost");
	AST_CLR: assert property (requestClear != 8'h00 |-> requestClear == 8'h01 << (ackType - 5'h08))
		else $error("cleared request does not match type");
	AST_SET: assert property (requestClear != 8'h00 |=>
		(serviceActive & $past(requestClear)) == $past(requestClear))
		else $error("in-service bit not set on acknowledge");
	AST_POLL: assert property (pollRd && interruptPending |=> requestClear != 8'h00 && !ackValid)
		else $error("poll read misbehaved");
	AST_VIEW: assert property (viewRd |=> requestClear == 8'h00)
		else $error("passive view acknowledged");
	AST_IDLE: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data without read");
	AST_NMI: assert property (nmiActive && !slaveMode |=> dmaSuspend || slaveMode)
		else $error("suspend not set during nmi");
	AST_SLAVE: assert property (slaveMode && $past(slaveMode) |-> !dmaSuspend)
		else $error("suspend active in slave mode");
	cover property (vectorAck && interruptPending);
	cover property (pollRd && interruptPending);
	cover property (nmiActive && !slaveMode);
endmodule

// >>> rtl/isv_params.svh
/*
 * Offsets, field positions, reset values and vector types of the
 * service-tracking registers. Included by the design.
 */
`ifndef ISV_PARAMS_SVH
`define ISV_PARAMS_SVH

// ============================================================
// register offsets
`define ISV_OFF_EOS      8'h22
`define ISV_OFF_POLL     8'h24
`define ISV_OFF_PVIEW    8'h26
`define ISV_OFF_SERVICE  8'h2C
`define ISV_OFF_SHARED   8'h30

// ============================================================
// field positions
`define ISV_ANYLVL_BIT   15
`define ISV_PEND_BIT     15
`define ISV_SUSPEND_BIT  15
`define ISV_TMR_SRC      3'h0
`define ISV_RSV_SRC      3'h1

// ============================================================
// reset values
`define ISV_SERVICE_RST  8'h00
`define ISV_TIMER_RST    3'h0
`define ISV_SUSPEND_RST  1'b0
`define ISV_TYPE_RST     5'h00

// ============================================================
// fixed vector types
`define ISV_VT_TIMER     5'h08
`define ISV_VT_BASE      5'h08

`endif

// >>> rtl/isv_pkg.sv
/*
 * Types shared by the service-tracking design.
 * Assumes isv_params.svh is on the include path.
 */
package isv_pkg;
	typedef logic [4:0]      isv_vtype_type;
	typedef logic [2:0]      isv_level_type;
	typedef logic [7:0][2:0] isv_levels_type;
endpackage

// >>> rtl/isv_service_track.sv
/*
 * Service tracking of a master-mode interrupt control unit: in-service
 * bits with nesting, acknowledging and passive poll, end-of-service
 * commands, shared timer pending bits and the DMA suspend bit.
 * Assumes request latching, masking and level storage live outside and
 * run on mclk; the peripheral register port is single-cycle strobes.
 */
// What this block does
// [R1] set a source's in-service bit on acknowledge, hold until end-of-service
// [R2] in-service bits: four external, two DMA, one timer; reset zero
// [R3] in-service bits gate nesting of new interrupts
// [R4] poll read acknowledges highest pending, updating all as vectoring does
// [R5] poll acknowledge runs no acknowledge bus cycle, fetches no vector
// [R6] passive poll view returns same content with no side effects
// [R7] poll registers: pending flag and five-bit type, reset zero
// [R8] end-of-service write clears the named source's in-service bit
// [R9] any-level flag clears highest-priority in-service bit only
// [R10] flag clear: type field selects which in-service bit to clear
// [R11] timers share one in-service bit, cleared by type 8
// [R12] suspend bit set during non-maskable processing; resets zero
// [R13] software reads and writes the suspend bit; it steers DMA
// [R14] three timer pending bits, set on request, cleared on acknowledge
// [R15] software avoids writing suspend bit while timer interrupts enabled
// [R16] suspend bit has no function in slave mode
// [R17] software writes zero to reserved bits
// [R18] software runs the routine for the type a poll returns
// [R19] acknowledge clears the source's request bit, vectored or polled
// [R20] each source has a three-bit level deciding highest priority
// [R21] end-of-service naming no set bit changes nothing
`timescale 1ns/10ps
`include "isv_params.svh"

module isv_service_track
	import isv_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           sys_rst,
	input  wire logic [7:0]     regAddr,
	input  wire logic           regRd,
	input  wire logic           regWr,
	input  wire logic [15:0]    regWrData,
	output logic      [15:0]    regRdData,
	input  wire logic [7:0]     requestBits,
	input  wire logic [7:0]     maskBits,
	input  wire isv_levels_type srcLevel,
	input  wire isv_level_type  priorityMask,
	input  wire logic           vectorAck,
	input  wire logic [2:0]     timerRequest,
	input  wire logic           nmiActive,
	input  wire logic           slaveMode,
	output logic [7:0]          requestClear,
	output logic [7:0]          serviceActive,
	output logic [4:0]          ackType,
	output logic                ackValid,
	output logic                interruptPending,
	output logic                dmaSuspend
);

	// ============================================================
	// helpers
	// returns {found, index} of the best source in v by level
	function automatic logic [3:0] pickBest(input logic [7:0] v, input isv_levels_type lv);
		logic          found;
		logic [2:0]    idx;
		isv_level_type best;
		found = 1'b0;
		idx   = 3'h0;
		best  = 3'h7;
		for (int i = 0; i < 8; i++) begin
			if (v[i] && (!found || lv[i] < best)) begin // R20
				found = 1'b1;
				idx   = 3'(i);
				best  = lv[i];
			end
		end
		return {found, idx};
	endfunction

	function automatic isv_vtype_type srcToType(input logic [2:0] idx);
		return isv_vtype_type'(`ISV_VT_BASE + {2'h0, idx});
	endfunction

	// type 8 and 10..15 name a source; anything else names none
	function automatic logic [7:0] typeToBit(input isv_vtype_type t);
		logic [7:0] b;
		b = 8'h00;
		if (t[4:3] == 2'h1 && t[2:0] != `ISV_RSV_SRC)
			b[t[2:0]] = 1'b1; // R11
		return b;
	endfunction

	// ============================================================
	// state
	logic [7:0]    service_q, service_d;
	logic [2:0]    timer_q, timer_d;
	logic          suspend_q, suspend_d;
	logic          pollPend_q;
	isv_vtype_type pollType_q;
	logic [15:0]   rdData_q, rdData_d;
	logic [7:0]    reqClr_q;
	logic [4:0]    ackType_q;
	logic          ackValid_q;

	// ============================================================
	// arbitration
	wire [3:0]          svcBest   = pickBest(service_q, srcLevel);
	wire isv_level_type svcLevel  = srcLevel[svcBest[2:0]];
	wire [7:0]          inLevel;
	wire [7:0]          eligible;
	wire [3:0]          pendBest;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gElig
			// nesting: only strictly higher than what is in service
			assign inLevel[g] = !svcBest[3] || (srcLevel[g] < svcLevel); // R3
		end
	endgenerate

	// source 1 has no hardware behind it
	assign eligible = requestBits & ~maskBits & inLevel & 8'hFD &
		{8{1'b1}} & ({srcLevel[7] <= priorityMask, srcLevel[6] <= priorityMask,
		srcLevel[5] <= priorityMask, srcLevel[4] <= priorityMask,
		srcLevel[3] <= priorityMask, srcLevel[2] <= priorityMask,
		srcLevel[1] <= priorityMask, srcLevel[0] <= priorityMask});
	assign pendBest = pickBest(eligible, srcLevel);

	// ============================================================
	// register port decode
	wire rdPoll    = regRd && regAddr == `ISV_OFF_POLL;
	wire rdView    = regRd && regAddr == `ISV_OFF_PVIEW;
	wire rdService = regRd && regAddr == `ISV_OFF_SERVICE;
	wire rdShared  = regRd && regAddr == `ISV_OFF_SHARED;
	wire wrEos     = regWr && regAddr == `ISV_OFF_EOS;
	wire wrShared  = regWr && regAddr == `ISV_OFF_SHARED;

	// acknowledge of the latched winner, by vectoring or by poll read
	wire       doAck   = (vectorAck || rdPoll) && pollPend_q; // R4 R5
	wire [7:0] ackBit  = doAck ? typeToBit(pollType_q) : 8'h00;
	wire       ackTmr  = ackBit[`ISV_TMR_SRC];

	wire        anyLevel = regWrData[`ISV_ANYLVL_BIT];
	wire [7:0]  eosBit   = !wrEos ? 8'h00 :
		anyLevel ? (svcBest[3] ? 8'(8'h01 << svcBest[2:0]) : 8'h00) : // R9
		typeToBit(regWrData[4:0]); // R10

	// lowest-numbered timer is retired first on a shared acknowledge
	wire [2:0] tmrClr = !ackTmr ? 3'h0 :
		timer_q[0] ? 3'h1 : timer_q[1] ? 3'h2 : timer_q[2] ? 3'h4 : 3'h0;

	wire [15:0] pollWord = {pollPend_q, 10'h000, pollType_q}; // R7

	// ============================================================
	// next state
	always_comb begin
		// clearing an already clear bit is harmless by construction
		service_d = (service_q & ~eosBit) | ackBit; // R1 R8 R21
		timer_d   = (timer_q & ~tmrClr) | timerRequest; // R14
		suspend_d = suspend_q;
		if (wrShared)
			suspend_d = regWrData[`ISV_SUSPEND_BIT]; // R13
		if (nmiActive)
			suspend_d = 1'b1; // R12
		rdData_d = 16'h0000;
		if (rdPoll || rdView)
			rdData_d = pollWord; // R6
		else if (rdService)
			rdData_d = {8'h00, service_q}; // R2
		else if (rdShared)
			rdData_d = {suspend_q, 12'h000, timer_q};
	end

	// ============================================================
	// flops
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			service_q  <= `ISV_SERVICE_RST; // R2
			timer_q    <= `ISV_TIMER_RST;
			suspend_q  <= `ISV_SUSPEND_RST;
			pollPend_q <= 1'b0; // R7
			pollType_q <= `ISV_TYPE_RST;
			rdData_q   <= 16'h0000;
			reqClr_q   <= 8'h00;
			ackType_q  <= 5'h00;
			ackValid_q <= 1'b0;
		end else begin
			service_q  <= service_d;
			timer_q    <= timer_d;
			suspend_q  <= suspend_d;
			// poll content is held off while an acknowledge is in flight
			pollPend_q <= doAck ? 1'b0 : pendBest[3];
			pollType_q <= doAck ? `ISV_TYPE_RST :
				(pendBest[3] ? srcToType(pendBest[2:0]) : `ISV_TYPE_RST);
			rdData_q   <= rdData_d;
			reqClr_q   <= ackBit; // R19
			ackType_q  <= doAck ? pollType_q : 5'h00;
			ackValid_q <= doAck && vectorAck;
		end
	end

	// ============================================================
	// outputs
	logic suspendOut_q;
	always_ff @(posedge mclk) begin
		if (sys_rst)
			suspendOut_q <= 1'b0;
		else
			suspendOut_q <= suspend_d && !slaveMode; // R16
	end

	logic [7:0] serviceOut_q;
	logic       pendOut_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			serviceOut_q <= 8'h00;
			pendOut_q    <= 1'b0;
		end else begin
			serviceOut_q <= service_d;
			// blanks with the poll flag so an acknowledge is never offered twice
			pendOut_q    <= doAck ? 1'b0 : pendBest[3]; // R7
		end
	end

	assign regRdData        = rdData_q;
	assign requestClear     = reqClr_q;
	assign serviceActive    = serviceOut_q;
	assign ackType          = ackType_q;
	assign ackValid         = ackValid_q;
	assign interruptPending = pendOut_q;
	assign dmaSuspend       = suspendOut_q;

endmodule
